// ==== src/ccp_pwm_cfg.svh ====
/*
  offsets, field positions, reset values and prescale counts of the
  capture/compare/pwm unit. assumes an 8-bit register port with 3 address bits.
*/
`ifndef CCP_PWM_CFG_SVH
`define CCP_PWM_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_UNIT_CONTROL   3'h0
`define OFS_DUTY_BUFFER    3'h1
`define OFS_DUTY_ACTIVE    3'h2
`define OFS_PERIOD         3'h3
`define OFS_TIMER_CONTROL  3'h4
`define OFS_TIMER_COUNT    3'h5
`define OFS_FLAGS          3'h6

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define TCON_ON_BIT        2
`define FLAG_EVENT_BIT     0
`define FLAG_TIMER_BIT     1
`define RST_BYTE           8'h00

// ----------------------------------------------------------------
// prescale chain terminal counts in oscillator periods and capture prescaler counts in rises, minus one
// ----------------------------------------------------------------
`define PRE_WRAP_1         6'h03
`define PRE_WRAP_4         6'h0f
`define PRE_WRAP_16        6'h3f
`define CAP_WRAP_4         4'h3
`define CAP_WRAP_16        4'hf

`endif

// ==== src/ccp_pwm_pkg.sv ====
/*
  types of the capture/compare/pwm unit: mode codes, control layout and the
  module state record. assumes nothing of its surroundings.
*/
`default_nettype none
package ccp_pwm_pkg;

  // mode select codes of the control register
  typedef enum logic [3:0] {
    mode_off      = 4'h0,
    mode_cmp_tgl  = 4'h2,
    mode_cap_fall = 4'h4,
    mode_cap_rise = 4'h5,
    mode_cap_r4   = 4'h6,
    mode_cap_r16  = 4'h7,
    mode_cmp_set  = 4'h8,
    mode_cmp_clr  = 4'h9,
    mode_cmp_soft = 4'ha,
    mode_cmp_trig = 4'hb
  } unit_mode_e;

  // control register layout
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_select;
  } unit_ctrl_s;

  // whole state of the unit
  typedef struct packed {
    unit_ctrl_s ctrl;          // unit_control_reg
    logic [7:0] duty_buf;      // duty_buffer_reg
    logic [7:0] duty_act;      // duty_active_latch
    logic [1:0] duty_hid;      // hidden low latch
    logic [7:0] period;        // period_register
    logic [2:0] tcon;          // period_timer_control
    logic [7:0] count;         // period_timer_count
    logic [5:0] chain;         // oscillator phase and prescaler
    logic       timer_flag;    // period_timer_flag
    logic       event_flag;    // unit_event_flag
    logic       pwm_q;         // pwm pin level
    logic       cmp_q;         // compare output latch
    logic [3:0] cap_cnt;       // capture edge prescaler
    logic [1:0] sync;          // capture pin synchroniser
    logic       cap_prev;      // previous synchronised level
    logic       cap_stb;       // capture pulse
    logic       t1_reset;      // special event timer reset pulse
    logic       adc_start;     // conversion start pulse
    logic [7:0] rdata;         // read data
  } unit_state_s;

endpackage : ccp_pwm_pkg

`default_nettype wire

// ==== src/ccp_standard_pwm.sv ====
/*
  capture/compare/pwm unit with standard pwm: period timer with prescaler,
  double buffered 10-bit duty, control register decode and a register port.
  assumes ref_clk is the oscillator, t1_match comes from the 16-bit timer
  comparator on the same clock, and the pin direction bit sits outside.
*/
// Chosen here: the address-and-strobe port and the address map.
// Contract
// - timer equals period: clear timer next increment
// - restart sets pin unless duty zero
// - buffered duty moves to latch at restart
// - period is (period+1) x4 x prescale
// - postscaler plays no part in pwm
// - duty is buffer byte with control bits 5:4
// - active latch read-only while pwm runs
// - latch plus hidden bits double buffer duty
// - time base is timer plus two low bits
// - time base equals duty latch clears pin
// - pulse width is duty x osc x prescale
// - cleared control register releases the pin
// - code 0000 off and resets unit state
// - 1010 flag only, 1011 special trigger
// - codes 11xx select standard pwm
`timescale 1ns/1ps
`default_nettype none
`include "ccp_pwm_cfg.svh"

module ccp_standard_pwm
  import ccp_pwm_pkg::*;
(
  input  wire logic       ref_clk,        // oscillator clock
  input  wire logic       nrst,           // async reset, active low
  input  wire logic       clk_en,         // freezes all state when low
  input  wire logic [2:0] addr,           // register address
  input  wire logic [7:0] wdata,          // write data
  input  wire logic       wr_stb,         // write strobe
  input  wire logic       rd_stb,         // read strobe
  output logic      [7:0] rdata,          // read data, cycle after strobe
  input  wire logic       capture_pin,    // pin level, asynchronous
  input  wire logic       t1_match,       // 16-bit compare match pulse
  input  wire logic       adc_enabled,    // converter is switched on
  output logic            pin_out,        // level driven on the pin
  output logic            pin_oe_n,       // low while the unit drives the pin
  output logic            capture_strobe, // one-cycle capture pulse
  output logic            t1_reset,       // one-cycle timer reset pulse
  output logic            adc_start       // one-cycle conversion start
);

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  unit_state_s s_reg;        // registered state
  unit_state_s s_next;       // next state
  logic [3:0]  mode;         // unit_mode_select
  logic        pwm_on;       // standard pwm selected
  logic        cap_on;       // any capture mode
  logic        timer_on;     // period_timer_on
  logic [5:0]  pre_wrap;     // prescale chain terminal count
  logic        tick;         // period timer increment cycle
  logic        restart;      // increment that closes a period
  logic [1:0]  low_bits;     // two low bits of the time base
  logic [9:0]  time_base;    // 10-bit time base
  logic [9:0]  duty_active;  // latched 10-bit duty
  logic [9:0]  duty_buffer;  // buffered 10-bit duty
  logic        rise;         // synchronised rising edge
  logic        fall;         // synchronised falling edge
  logic        cap_evt;      // capture condition met
  logic        claim;        // unit owns the pin
  logic [5:0]  chain_step;   // chain value after this edge
  logic [1:0]  low_next;     // low time base bits after this edge
  logic [9:0]  base_next;    // time base after this edge
  logic        event_set;    // hardware sets the event flag

  assign mode        = s_reg.ctrl.unit_mode_select;
  assign pwm_on      = (mode[3:2] == 2'b11);
  assign cap_on      = (mode[3:2] == 2'b01);
  assign timer_on    = s_reg.tcon[`TCON_ON_BIT];
  assign duty_active = {s_reg.duty_act, s_reg.duty_hid};
  assign duty_buffer = {s_reg.duty_buf, s_reg.ctrl.duty_low_bits};
  assign rise        = s_reg.sync[1] & ~s_reg.cap_prev;
  assign fall        = ~s_reg.sync[1] & s_reg.cap_prev;

  // ----------------------------------------------------------------
  // prescale chain: oscillator phase below instruction prescaler
  // ----------------------------------------------------------------
  // one chain serves all ratios, so the low time base bits always come
  // from the two chain bits just under the timer increment
  always_comb
  begin
    unique case (s_reg.tcon[1:0])
      2'b00:   pre_wrap = `PRE_WRAP_1;
      2'b01:   pre_wrap = `PRE_WRAP_4;
      default: pre_wrap = `PRE_WRAP_16;
    endcase
    unique case (s_reg.tcon[1:0])
      2'b00:   low_bits = s_reg.chain[1:0];                 // phase bits
      2'b01:   low_bits = s_reg.chain[3:2];
      default: low_bits = s_reg.chain[5:4];
    endcase
    unique case (s_reg.tcon[1:0])
      2'b00:   low_next = chain_step[1:0];
      2'b01:   low_next = chain_step[3:2];
      default: low_next = chain_step[5:4];
    endcase
  end

  // postscaler never enters here: the period ends on the match only
  assign tick      = timer_on & (s_reg.chain == pre_wrap);
  assign restart   = tick & (s_reg.count == s_reg.period);
  assign time_base = {s_reg.count, low_bits};
  assign claim     = pwm_on | (mode == mode_cmp_tgl) | (mode == mode_cmp_set) | (mode == mode_cmp_clr);
  assign chain_step = timer_on ? (tick ? 6'h00 : 6'(s_reg.chain + 6'h01)) : s_reg.chain;
  assign base_next  = {restart ? 8'h00 : (tick ? 8'(s_reg.count + 8'h01) : s_reg.count), low_next};
  assign event_set  = cap_evt | (t1_match & ~pwm_on & (mode[3] | (mode == mode_cmp_tgl)));

  // capture condition per code
  always_comb
  begin
    unique case (mode)
      mode_cap_fall: cap_evt = fall;
      mode_cap_rise: cap_evt = rise;
      mode_cap_r4:   cap_evt = rise & (s_reg.cap_cnt == `CAP_WRAP_4);
      mode_cap_r16:  cap_evt = rise & (s_reg.cap_cnt == `CAP_WRAP_16);
      default:       cap_evt = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next           = s_reg;
    s_next.cap_stb   = 1'b0;
    s_next.t1_reset  = 1'b0;
    s_next.adc_start = 1'b0;
    // synchroniser: only the second stage is looked at
    s_next.sync      = {s_reg.sync[0], capture_pin};
    s_next.cap_prev  = s_reg.sync[1];

    // prescale chain and period timer
    if (timer_on)
    begin
      s_next.chain = chain_step;
    end
    if (restart)
    begin
      s_next.count      = 8'h00;
      s_next.timer_flag = 1'b1;
      s_next.duty_act   = pwm_on ? s_reg.duty_buf : s_reg.duty_act;
      s_next.duty_hid   = pwm_on ? s_reg.ctrl.duty_low_bits : s_reg.duty_hid;
    end
    else if (tick)
    begin
      s_next.count = 8'(s_reg.count + 8'h01);
    end

    // pwm pin falls on the edge where the time base steps onto the duty, so it
    // is high for exactly duty steps; a duty beyond the period never matches
    if (pwm_on)
    begin
      if (restart)
      begin
        s_next.pwm_q = (duty_buffer != 10'h000);
      end
      else if (base_next == duty_active)
      begin
        s_next.pwm_q = 1'b0;
      end
    end
    else
    begin
      s_next.pwm_q = 1'b0;
    end

    // capture edge prescaler clears outside capture modes
    if (!cap_on)
    begin
      s_next.cap_cnt = 4'h0;
    end
    else if (cap_evt)
    begin
      s_next.cap_cnt = 4'h0;
    end
    else if (rise)
    begin
      s_next.cap_cnt = 4'(s_reg.cap_cnt + 4'h1);
    end
    if (cap_evt)
    begin
      s_next.cap_stb    = 1'b1;
      s_next.event_flag = 1'b1;
    end

    // compare actions on a match
    if (t1_match)
    begin
      unique case (mode)
        mode_cmp_tgl:
        begin
          s_next.cmp_q      = ~s_reg.cmp_q;
          s_next.event_flag = 1'b1;
        end
        mode_cmp_set:
        begin
          s_next.cmp_q      = 1'b1;
          s_next.event_flag = 1'b1;
        end
        mode_cmp_clr:
        begin
          s_next.cmp_q      = 1'b0;
          s_next.event_flag = 1'b1;
        end
        mode_cmp_soft:
        begin
          s_next.event_flag = 1'b1;
        end
        mode_cmp_trig:
        begin
          s_next.event_flag = 1'b1;
          s_next.t1_reset   = 1'b1;
          s_next.adc_start  = adc_enabled;
        end
        default:       s_next.cmp_q = s_reg.cmp_q;               // no pin action
      endcase
    end

    // off: compare latch, capture edge prescaler and hidden duty bits return to their idle values
    if (mode == mode_off)
    begin
      s_next.cmp_q    = 1'b0;
      s_next.cap_cnt  = 4'h0;
      s_next.duty_hid = 2'b00;
    end

    // register writes; hardware-set flags win over a clear
    if (wr_stb)
    begin
      unique case (addr)
        `OFS_UNIT_CONTROL:
        begin
          s_next.ctrl = unit_ctrl_s'({2'b00, wdata[5:0]});
          if (wdata[3:0] == mode_cmp_set)
          begin
            s_next.cmp_q = 1'b0;                                 // init low
          end
          if (wdata[3:0] == mode_cmp_clr)
          begin
            s_next.cmp_q = 1'b1;                                 // init high
          end
        end
        `OFS_DUTY_BUFFER:  s_next.duty_buf = wdata;              // any time
        `OFS_DUTY_ACTIVE:
        begin
          if (!pwm_on)
          begin
            s_next.duty_act = wdata;
          end
        end
        `OFS_PERIOD:        s_next.period = wdata;
        `OFS_TIMER_CONTROL: s_next.tcon   = wdata[2:0];
        `OFS_TIMER_COUNT:   s_next.count  = wdata;
        `OFS_FLAGS:
        begin
          s_next.timer_flag = wdata[`FLAG_TIMER_BIT] | restart;
          s_next.event_flag = wdata[`FLAG_EVENT_BIT] | event_set;
        end
        default:            ;                                    // unmapped: write ignored
      endcase
    end

    // read data for the cycle after the strobe, zero otherwise
    s_next.rdata = 8'h00;
    if (rd_stb)
    begin
      unique case (addr)
        `OFS_UNIT_CONTROL:  s_next.rdata = {2'b00, s_reg.ctrl.duty_low_bits, mode};
        `OFS_DUTY_BUFFER:   s_next.rdata = s_reg.duty_buf;
        `OFS_DUTY_ACTIVE:   s_next.rdata = s_reg.duty_act;
        `OFS_PERIOD:        s_next.rdata = s_reg.period;
        `OFS_TIMER_CONTROL: s_next.rdata = {5'h00, s_reg.tcon};
        `OFS_TIMER_COUNT:   s_next.rdata = s_reg.count;
        `OFS_FLAGS:         s_next.rdata = {6'h00, s_reg.timer_flag, s_reg.event_flag};
        default:            s_next.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset brings every field to zero: unit off, pin released
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
    end
    else if (clk_en)
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a cleared control register gives the pin back to the port
  assign pin_oe_n       = ~claim;
  assign pin_out        = pwm_on ? s_reg.pwm_q : (claim & s_reg.cmp_q);
  assign rdata          = s_reg.rdata;
  assign capture_strobe = s_reg.cap_stb;
  assign t1_reset       = s_reg.t1_reset;
  assign adc_start      = s_reg.adc_start;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_period_restart: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && restart && !wr_stb) |=> (s_reg.count == 8'h00))
    else $error("period timer not cleared at period end");

  a_pin_set_restart: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && restart && pwm_on && duty_buffer != 10'h000 && !wr_stb) |=> s_reg.pwm_q)
    else $error("pin not set at period restart");

  a_zero_duty_low: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && restart && pwm_on && duty_buffer == 10'h000 && !wr_stb) |=> !s_reg.pwm_q)
    else $error("pin set with zero duty");

  a_duty_latch_move: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && restart && pwm_on) |=> (duty_active == $past(duty_buffer)))
    else $error("duty not latched at restart");

  a_latch_read_only: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && pwm_on && !restart && wr_stb && addr == `OFS_DUTY_ACTIVE) |=> $stable(s_reg.duty_act))
    else $error("active duty latch written in pwm mode");

  a_match_clears_pin: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && pwm_on && !restart && base_next == duty_active && !wr_stb) |=> !pin_out)
    else $error("pin not cleared on time base match");

  a_off_releases_pin: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_reg.ctrl == unit_ctrl_s'(`RST_BYTE)) |-> (pin_oe_n && !pin_out))
    else $error("pin still driven with control cleared");

  a_off_resets_state: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && mode == mode_off && !wr_stb) |=> (s_reg.cap_cnt == 4'h0 && !s_reg.cmp_q && s_reg.duty_hid == 2'b00))
    else $error("unit state not reset in off mode");

  a_control_readback: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && rd_stb && addr == `OFS_UNIT_CONTROL) |=> (rdata[7:6] == 2'b00 && rdata[5:0] == $past(s_reg.ctrl[5:0])))
    else $error("control register read back wrong");

  a_special_trigger: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && t1_match && mode == mode_cmp_trig && !wr_stb) |=> (t1_reset && adc_start == $past(adc_enabled) && pin_oe_n))
    else $error("special event trigger missing");

endmodule : ccp_standard_pwm

`default_nettype wire

// ==== tb/ccp_standard_pwm_tb.sv ====
/*
  self-checking bench of the standard pwm unit: register port tasks, pwm
  waveform measured through the load model. assumes a 10 MHz oscillator.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccp_pwm_cfg.svh"

module ccp_standard_pwm_tb;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic       ref_clk = 1'b0;     // oscillator
  logic       nrst = 1'b0;        // reset, active low
  logic       clk_en = 1'b1;      // always running
  logic [2:0] addr = 3'h0;        // register address
  logic [7:0] wdata = 8'h00;      // write data
  logic       wr_stb = 1'b0;      // write strobe
  logic       rd_stb = 1'b0;      // read strobe
  logic [7:0] rdata;              // read data
  logic       pin_out;            // pin level
  logic       pin_oe_n;           // pin drive enable, low active
  logic       level;              // level at the load
  logic       rise;               // switch-on edge
  logic       capture_pin = 1'b0; // capture input pin
  logic       t1_match = 1'b0;    // compare match pulse
  logic       adc_enabled = 1'b0; // converter switched on
  logic       capture_strobe;     // capture pulse out
  logic       t1_reset;           // timer reset pulse out
  logic       adc_start;          // conversion start pulse out
  logic [7:0] v;                  // scratch read value
  logic [15:0] hi;                // high cycles in a window
  logic [15:0] rs;                // switch-on edges in a window
  logic       got;                // flag seen
  int         n_errors = 0;       // mismatch count
  int         samples_checked = 0;// comparison count
  // case table: timer control, control byte, duty byte, window, highs, edges
  logic [7:0]  tc[5] = '{8'h04, 8'h04, 8'h04, 8'h05, 8'h06};
  logic [7:0]  ct[5] = '{8'h1c, 8'h0c, 8'h0c, 8'h1c, 8'h2c};
  logic [7:0]  db[5] = '{8'h02, 8'h00, 8'h04, 8'h02, 8'h01};
  logic [15:0] wn[5] = '{16'd64, 16'd64, 16'd64, 16'd256, 16'd1024};
  logic [15:0] eh[5] = '{16'd36, 16'd0, 16'd64, 16'd144, 16'd384};
  logic [15:0] er[5] = '{16'd4, 16'd0, 16'd0, 16'd4, 16'd4};
  // capture strobes per code 0100..0111 over 16 pin periods
  logic [15:0] cs[4] = '{16'd16, 16'd16, 16'd4, 16'd1};

  always #50 ref_clk = ~ref_clk;

  ccp_standard_pwm DUT (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .capture_pin(capture_pin), .t1_match(t1_match),
    .adc_enabled(adc_enabled), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .capture_strobe(capture_strobe),
    .t1_reset(t1_reset), .adc_start(adc_start));

  pwm_load load (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .level(level), .rise(rise));

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  // one-cycle write; #1 lets the write edge settle before callers look
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr

  // read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // counts high cycles and edges over whole periods, so phase does not matter
  task automatic meas(input logic [15:0] n);
    hi = 16'h0;
    rs = 16'h0;
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
      if (level === 1'b1) hi++;
      if (rise === 1'b1) rs++;
    end
  endtask : meas

  // one-cycle compare match; returns just after the edge that acts on it
  task automatic pulse_match(input logic en);
    @(posedge ref_clk);
    t1_match    <= 1'b1;
    adc_enabled <= en;
    @(posedge ref_clk);
    t1_match    <= 1'b0;
    #1;
  endtask : pulse_match

  // square wave on the capture pin, strobes counted while it runs
  task automatic edges(input logic [7:0] n);
    rs = 16'h0;
    repeat (n)
    begin
      repeat (2)
      begin
        @(posedge ref_clk);
        capture_pin <= ~capture_pin;
        repeat (4)
        begin
          @(posedge ref_clk);
          #1;
          if (capture_strobe === 1'b1) rs++;
        end
      end
    end
  endtask : edges

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(`OFS_UNIT_CONTROL, v); chk("ctrl_reset", 16'h00, {8'h0, v});
    rd(`OFS_TIMER_COUNT, v); chk("count_reset", 16'h00, {8'h0, v});
    chk("oe_reset", 16'h1, {15'h0, pin_oe_n});
    wr(3'h7, 8'h5a);
    rd(3'h7, v); chk("unmapped", 16'h00, {8'h0, v});
    wr(`OFS_UNIT_CONTROL, 8'hff);
    rd(`OFS_UNIT_CONTROL, v); chk("ctrl_top_bits", 16'h3f, {8'h0, v});
    chk("oe_pwm", 16'h0, {15'h0, pin_oe_n});
    wr(`OFS_UNIT_CONTROL, 8'h00);
    chk("oe_off", 16'h1, {15'h0, pin_oe_n});
    // documented bring-up order, then wait for the first period end
    wr(`OFS_PERIOD, 8'h03);
    wr(`OFS_UNIT_CONTROL, 8'h1c);
    wr(`OFS_DUTY_BUFFER, 8'h02);
    wr(`OFS_FLAGS, 8'h00);
    wr(`OFS_TIMER_CONTROL, 8'h04);
    got = 1'b0;
    for (int i = 0; i < 50 && !got; i++)
    begin
      rd(`OFS_FLAGS, v);
      got = (v[`FLAG_TIMER_BIT] === 1'b1);
    end
    chk("timer_flag", 16'h1, {15'h0, got});
    if (!got) tally_and_finish();
    // duty and period over every prescale; settle three periods first
    for (int k = 0; k < 5; k++)
    begin
      wr(`OFS_UNIT_CONTROL, ct[k]);
      wr(`OFS_DUTY_BUFFER, db[k]);
      wr(`OFS_TIMER_CONTROL, tc[k]);
      repeat (3 * wn[k] / 4) @(posedge ref_clk);
      meas(wn[k]);
      chk("high_cycles", eh[k], hi);
      chk("period_edges", er[k], rs);
    end
    // latch is read-only under pwm and holds the last restart value
    wr(`OFS_DUTY_ACTIVE, 8'haa);
    rd(`OFS_DUTY_ACTIVE, v); chk("duty_latch", 16'h01, {8'h0, v});
    wr(`OFS_UNIT_CONTROL, 8'h00);
    chk("oe_release", 16'h1, {15'h0, pin_oe_n});
    chk("load_level", 16'h0, {15'h0, level});
    // compare pin actions, seen at the load
    wr(`OFS_UNIT_CONTROL, 8'h08); chk("cmp_init_low", 16'h0, {15'h0, level});
    pulse_match(1'b0); chk("cmp_set", 16'h1, {15'h0, level});
    wr(`OFS_UNIT_CONTROL, 8'h09); chk("cmp_init_high", 16'h1, {15'h0, level});
    pulse_match(1'b0); chk("cmp_clear", 16'h0, {15'h0, level});
    wr(`OFS_UNIT_CONTROL, 8'h02);
    pulse_match(1'b0); chk("cmp_toggle_hi", 16'h1, {15'h0, level});
    pulse_match(1'b0); chk("cmp_toggle_lo", 16'h0, {15'h0, level});
    wr(`OFS_FLAGS, 8'h00);
    rd(`OFS_FLAGS, v); chk("event_cleared", 16'h0, {15'h0, v[`FLAG_EVENT_BIT]});
    // flag-only code leaves the pin alone
    wr(`OFS_UNIT_CONTROL, 8'h0a); chk("soft_oe", 16'h1, {15'h0, pin_oe_n});
    pulse_match(1'b0); chk("soft_no_reset", 16'h0, {15'h0, t1_reset});
    rd(`OFS_FLAGS, v); chk("soft_flag", 16'h1, {15'h0, v[`FLAG_EVENT_BIT]});
    // clear in the cycle of a match: the hardware set must win
    @(posedge ref_clk);
    wr_stb   <= 1'b1;
    addr     <= `OFS_FLAGS;
    wdata    <= 8'h00;
    t1_match <= 1'b1;
    @(posedge ref_clk);
    wr_stb   <= 1'b0;
    t1_match <= 1'b0;
    rd(`OFS_FLAGS, v); chk("flag_set_wins", 16'h1, {15'h0, v[`FLAG_EVENT_BIT]});
    // special trigger, with and without the converter
    wr(`OFS_UNIT_CONTROL, 8'h0b);
    pulse_match(1'b1); chk("trig_reset", 16'h1, {15'h0, t1_reset});
    chk("trig_adc", 16'h1, {15'h0, adc_start});
    pulse_match(1'b0); chk("trig_adc_off", 16'h0, {15'h0, adc_start});
    chk("trig_oe", 16'h1, {15'h0, pin_oe_n});
    // capture codes: falling, rising, every 4th and every 16th rise
    wr(`OFS_FLAGS, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(`OFS_UNIT_CONTROL, 8'(8'h04 + k));
      edges(8'd16);
      chk("capture_strobes", cs[k], rs);
    end
    rd(`OFS_FLAGS, v); chk("capture_flag", 16'h1, {15'h0, v[`FLAG_EVENT_BIT]});
    wr(`OFS_UNIT_CONTROL, 8'h00);
    rd(`OFS_UNIT_CONTROL, v); chk("ctrl_cleared", 16'h00, {8'h0, v});
    tally_and_finish();
  end
endmodule : ccp_standard_pwm_tb
`default_nettype wire

// ==== tb/pwm_load.sv ====
/*
  model of the power switching load on the pwm pin.
  assumes the pin has a pull-down at the gate, so a released pin reads low.
*/
`timescale 1ns/1ps
`default_nettype none

module pwm_load
(
  input  wire logic ref_clk,  // oscillator clock
  input  wire logic pin_out,  // level the unit drives
  input  wire logic pin_oe_n, // low while the unit drives
  output logic      level,    // level seen at the gate
  output logic      rise      // high in the cycle after a low-to-high step
);
  // ----------------------------------------
  // gate level and edge detect
  // ----------------------------------------
  logic prev_lvl = 1'b0; // level one cycle ago

  // pull-down wins whenever the unit lets go of the pin
  assign level = pin_oe_n ? 1'b0 : pin_out;
  assign rise  = level & ~prev_lvl;

  // remember last level to spot switch-on edges
  always_ff @(posedge ref_clk)
    prev_lvl <= level;
endmodule : pwm_load
`default_nettype wire
